// ==== tb/cfg_store_props.sv ====
`timescale 1ns/1ps
module cfg_store_props
    import cfg_store_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         nrst,
    input wire logic         ce,
    input wire cmd_type      cmd,
    input wire logic         open_access_mode,
    input wire gauge_in_type gauge,
    input wire logic [7:0]   rd_data_reg,
    input wire logic         rd_valid_reg,
    input wire logic         busy_reg,
    input wire logic         charge_overtemp_flag,
    input wire logic         discharge_overtemp_flag,
    input wire logic         charge_done_flag
);
    // ====
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_lock_sel;
        ce && cmd.wr && !busy_reg && !open_access_mode && cmd.addr == ADDR_BLOCK;
    endsequence
    a_read_answer: assert property (ce && cmd.rd |=> rd_valid_reg) else $error("no answer");
    a_valid_cause: assert property (rd_valid_reg |-> $past(ce && cmd.rd)) else $error("stray");
    a_unmapped_zero: assert property (ce && cmd.rd && cmd.addr == 7'h70 |=> rd_data_reg == 8'h00)
        else $error("unmapped");
    a_locked_class:
        assert property (ce && cmd.rd && !open_access_mode && cmd.addr == ADDR_CLASS
            |=> rd_data_reg == 8'h00) else $error("class seen");
    a_page_load: assert property (s_lock_sel ##0 (cmd.data inside {[8'h01:8'h03]})
        |=> busy_reg [*8]) else $error("no load");
    a_bad_page: assert property (s_lock_sel ##0 !(cmd.data inside {[8'h01:8'h03]})
        |=> !busy_reg) else $error("blocked load");
    a_otc_cause: assert property ($rose(charge_overtemp_flag) |-> $past(gauge.charging))
        else $error("chg flag");
    a_otd_cause: assert property ($rose(discharge_overtemp_flag) |-> $past(gauge.discharging))
        else $error("dsg flag");
    a_done_cause: assert property ($rose(charge_done_flag) |-> $past(gauge.charging))
        else $error("done flag");
endmodule // cfg_store_props
bind config_store_block_access cfg_store_props u_props (.*);

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
module host_model
    import cfg_store_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic [7:0] rd_data_reg,
    output cmd_type        cmd
);
    // ====
    // byte transfers
    initial cmd = '0;
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        cmd = '{1'b1, 1'b0, a, v};
        @(negedge clk_sys);
        cmd = '{1'b0, 1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        cmd = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys);
        cmd = '{1'b0, 1'b0, ~a, 8'hFF};
        v = rd_data_reg;
    endtask
endmodule // host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import cfg_store_pkg::*;;
    logic         clk_sys = 0, nrst = 0, ce = 1, open_access_mode = 1;
    gauge_in_type gauge = '0;
    cmd_type      cmd;
    logic [7:0]   rd_data_reg, d;
    logic         rd_valid_reg, busy_reg, f_chg, f_dsg, f_done;
    int           err_total = 0, tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    host_model host (.clk_sys(clk_sys), .rd_data_reg(rd_data_reg), .cmd(cmd));
    config_store_block_access #(.COMMIT_WAIT(20), .JOINT_WAIT(30), .PREP_WAIT(25)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .cmd(cmd), .open_access_mode(open_access_mode),
        .gauge(gauge), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
        .busy_reg(busy_reg), .charge_overtemp_flag(f_chg), .discharge_overtemp_flag(f_dsg),
        .charge_done_flag(f_done));
    // ====
    // tasks
    task automatic check(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 400 && busy_reg !== 1'b0; i++) @(negedge clk_sys);
        if (busy_reg !== 1'b0) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic put_blk(input logic [7:0] b, base, input logic good);
        logic [7:0] s = 8'h00;
        host.wr(ADDR_BLOCK, b);
        wait_idle();
        for (int i = 0; i < WINDOW_BYTES; i++) begin
            host.wr(ADDR_WINDOW + 7'(i), base + 8'(i));
            s += base + 8'(i);
        end
        host.wr(ADDR_CHECKSUM, CHECKSUM_BASE - s + {7'h00, !good});
        wait_idle();
    endtask
    task automatic get_blk(input logic [7:0] b, base);
        host.wr(ADDR_BLOCK, b);
        wait_idle();
        for (int i = 0; i < WINDOW_BYTES; i++) begin
            host.rd(ADDR_WINDOW + 7'(i), d);
            check(base + 8'(i), d);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            gauge.tick_1s = 1'b1;
            @(negedge clk_sys);
            gauge.tick_1s = 1'b0;
            @(negedge clk_sys);
        end
    endtask
    // ====
    // sequence
    initial begin
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        host.wr(ADDR_SETUP, SETUP_GENERAL);
        host.wr(ADDR_CLASS, MAKER_CLASS);
        put_blk(8'h00, 8'h10, 1'b1);
        put_blk(8'h01, 8'h40, 1'b1);
        put_blk(8'h01, 8'h80, 1'b0);
        get_blk(8'h00, 8'h10);
        get_blk(8'h01, 8'h40);
        host.rd(7'h70, d);
        check(8'h00, d);
        check(8'h01, {7'h00, rd_valid_reg});
        open_access_mode = 1'b0;
        host.wr(ADDR_CLASS, SAFETY_CLASS);
        host.rd(ADDR_CLASS, d);
        check(8'h00, d);
        get_blk(8'h02, 8'h40);
        put_blk(8'h01, 8'hA0, 1'b1);
        get_blk(8'h01, 8'h10);
        put_blk(8'h03, 8'hC0, 1'b1);
        get_blk(8'h03, 8'hC0);
        host.wr(ADDR_BLOCK, 8'h00);
        check(8'h00, {7'h00, busy_reg});
        gauge = '{16'h0258, 16'h0032, DEF_CHARGE_V, 1'b1, 1'b0, 1'b0};
        ticks(3);
        check(8'h01, {7'h00, f_chg});
        gauge.temp = DEF_OTC_REC;
        ticks(1);
        check(8'h00, {7'h00, f_chg});
        ticks(40);
        check(8'h01, {7'h00, f_done});
        gauge = '{16'h0258, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b0};
        ticks(3);
        check(8'h01, {7'h00, f_dsg});
        check(8'h00, {7'h00, f_done});
        open_access_mode = 1'b1;
        host.rd(ADDR_CLASS, d);
        check(MAKER_CLASS, d);
        host.wr(ADDR_CONTROL_LO, SUB_JOINT_START[7:0]);
        host.wr(ADDR_CONTROL_HI, SUB_JOINT_START[15:8]);
        host.rd(ADDR_CONTROL_LO, d);
        check(8'h11, d);
        repeat (30) @(negedge clk_sys);
        host.rd(ADDR_CONTROL_LO, d);
        check(8'h01, d);
        for (int c = 224; c < 228; c++) begin
            host.wr(ADDR_CLASS, 8'(c));
            put_blk(8'h00, 8'(c), 1'b1);
        end
        host.wr(ADDR_CONTROL_LO, SUB_JOINT_POLL[7:0]);
        host.wr(ADDR_CONTROL_HI, SUB_JOINT_POLL[15:8]);
        wait_idle();
        host.rd(ADDR_CONTROL_LO, d);
        check(8'h20, d);
        put_blk(8'h00, 8'h55, 1'b1);
        get_blk(8'h00, 8'hE3);
        complete_run();
    end
endmodule // tb_top

// ==== verilog/cfg_store_pkg.sv ====
package cfg_store_pkg;

    // ==========================================================
    // command addresses
    localparam logic [6:0] ADDR_CONTROL_LO  = 7'h00;
    localparam logic [6:0] ADDR_CONTROL_HI  = 7'h01;
    localparam logic [6:0] ADDR_CLASS       = 7'h3E;
    localparam logic [6:0] ADDR_BLOCK       = 7'h3F;
    localparam logic [6:0] ADDR_WINDOW      = 7'h40;
    localparam logic [6:0] ADDR_WINDOW_LAST = 7'h5F;
    localparam logic [6:0] ADDR_CHECKSUM    = 7'h60;
    localparam logic [6:0] ADDR_SETUP       = 7'h61;

    // ==========================================================
    // values and field positions
    localparam int          WINDOW_BYTES    = 32;
    localparam int          BYTE_IDX_W      = 5;
    localparam logic [7:0]  SETUP_GENERAL   = 8'h00;
    localparam logic [7:0]  SETUP_RESET     = 8'h01;
    localparam logic [7:0]  CHECKSUM_BASE   = 8'hFF;
    localparam logic [15:0] SUB_JOINT_START = 16'h0094;
    localparam logic [15:0] SUB_JOINT_POLL  = 16'h0095;
    localparam logic [7:0]  JOINT_FIRST     = 8'hE0;
    localparam logic [7:0]  JOINT_LAST      = 8'hE3;
    localparam logic [3:0]  JOINT_ALL       = 4'hF;
    localparam logic [7:0]  MAKER_CLASS     = 8'h3A;
    localparam logic [7:0]  MAKER_SEL_A     = 8'h01;
    localparam logic [7:0]  MAKER_SEL_C     = 8'h03;
    localparam int          MAKER_PAGES     = 3;
    localparam int          STAT_JOINT_BIT  = 0;
    localparam int          STAT_PREP_BIT   = 4;
    localparam int          STAT_LOCK_BIT   = 5;
    localparam logic [7:0]  SAFETY_CLASS    = 8'h02;
    localparam logic [7:0]  TAPER_CLASS     = 8'h24;

    // parameter byte offsets inside block 0 of their class
    localparam int OFS_OTC_TH   = 0;
    localparam int OFS_OTC_TIME = 2;
    localparam int OFS_OTC_REC  = 3;
    localparam int OFS_OTD_TH   = 5;
    localparam int OFS_OTD_TIME = 7;
    localparam int OFS_OTD_REC  = 8;
    localparam int OFS_TAPER_I  = 2;
    localparam int OFS_TAPER_V  = 6;
    localparam int OFS_TAPER_W  = 8;

    // stored parameter defaults
    localparam logic [15:0] DEF_OTC_TH    = 16'h0226;
    localparam logic [15:0] DEF_OTC_REC   = 16'h01F4;
    localparam logic [7:0]  DEF_OTC_TIME  = 8'h02;
    localparam logic [15:0] DEF_OTD_TH    = 16'h0258;
    localparam logic [15:0] DEF_OTD_REC   = 16'h0226;
    localparam logic [7:0]  DEF_OTD_TIME  = 8'h02;
    localparam logic [15:0] DEF_TAPER_I   = 16'h0064;
    localparam logic [15:0] DEF_TAPER_V   = 16'h0064;
    localparam logic [7:0]  DEF_TAPER_WIN = 8'h28;
    localparam logic [15:0] DEF_CHARGE_V  = 16'h1068;

    // ==========================================================
    // timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int COMMIT_WAIT_MS = 120;
    localparam int JOINT_WAIT_MS  = 250;
    localparam int PREP_WAIT_MS   = 200;
    localparam int COMMIT_WAIT_CYCLES = COMMIT_WAIT_MS * (CLK_HZ / 1000);
    localparam int JOINT_WAIT_CYCLES  = JOINT_WAIT_MS * (CLK_HZ / 1000);
    localparam int PREP_WAIT_CYCLES   = PREP_WAIT_MS * (CLK_HZ / 1000);
    localparam int WAIT_W             = 23;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LOAD   = 2'b01,
        ST_COMMIT = 2'b10,
        ST_WAIT   = 2'b11
    } state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } cmd_type;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] current;
        logic [15:0] voltage;
        logic        charging;
        logic        discharging;
        logic        tick_1s;
    } gauge_in_type;

    typedef struct packed {
        logic [15:0] otc_th;
        logic [15:0] otc_rec;
        logic [7:0]  otc_time;
        logic [15:0] otd_th;
        logic [15:0] otd_rec;
        logic [7:0]  otd_time;
        logic [15:0] taper_i;
        logic [15:0] taper_v;
        logic [7:0]  taper_win;
    } limits_type;

endpackage

// ==== verilog/config_store_block_access.sv ====
// Function
// - block select 0x3f picks 32-byte block index of the class
// - class offset N appears at window address 0x40 plus N mod 32
// - long classes handled by repeating block select and window transfer
// - classes 224-227 commit only inside the joint-write procedure
// - 0x0095 poll; status bit 4 set means wait 200 ms, retry
// - status bit 5 shows joint classes can no longer be written
// - 96 bytes of maker pages A, B and C
// - open mode reaches maker pages as class 58, page B block 1
// - locked mode refuses access setup and class select writes
// - locked mode block select 1/2/3 loads page A/B/C into window
// - locked mode good checksum stores edited maker page back
// - locked mode never commits page A
// - locked mode blocks all stored data except maker pages
// - charge over-temp flag: threshold, time, recovery; time zero disables
// - discharge over-temp flag: threshold, time, recovery; time zero disables
// - charge termination from taper current, voltage and window
// - checksum equals 255 minus 8-bit sum of the 32 window bytes
`timescale 1ns/1ps
module config_store_block_access
    import cfg_store_pkg::*;
#(
    parameter int BLK_W              = 2,
    parameter int COMMIT_WAIT        = COMMIT_WAIT_CYCLES,
    parameter int JOINT_WAIT         = JOINT_WAIT_CYCLES,
    parameter int PREP_WAIT          = PREP_WAIT_CYCLES,
    parameter logic [15:0] CHARGE_V  = DEF_CHARGE_V
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire cmd_type      cmd,
    input  wire logic         open_access_mode,
    input  wire gauge_in_type gauge,
    output logic [7:0]        rd_data_reg,
    output logic              rd_valid_reg,
    output logic              busy_reg,
    output logic              charge_overtemp_flag,
    output logic              discharge_overtemp_flag,
    output logic              charge_done_flag
);

    localparam int MEM_AW = 8 + BLK_W + BYTE_IDX_W;

    state_type        state_reg;
    logic [5:0]       cnt_reg;
    logic [WAIT_W-1:0] wait_reg;
    logic [WAIT_W-1:0] prep_reg;
    logic [7:0]       class_reg;
    logic [7:0]       block_reg;
    logic [7:0]       setup_reg;
    logic [7:0]       checksum_reg;
    logic [7:0]       ctrl_lo_reg;
    logic [15:0]      control_reg;
    logic [7:0]       window_reg [WINDOW_BYTES];
    logic [7:0]       mem_class_reg;
    logic [BLK_W-1:0] mem_block_reg;
    logic             loaded_reg;
    logic             joint_mode_reg;
    logic [3:0]       joint_mask_reg;
    logic             joint_lock_reg;
    limits_type       limits_reg;
    logic [7:0]       mem_rdata;
    logic [7:0]       win_sum;
    logic             locked;
    logic             idle_wr;
    logic             load_go;
    logic [7:0]       load_class;
    logic [BLK_W-1:0] load_block;
    logic             is_joint;
    logic             target_ok;
    logic             commit_go;
    logic             ctrl_go;
    logic [15:0]      ctrl_word;
    logic             finish_go;
    logic [4:0]       win_idx;

    assign locked    = !open_access_mode;
    assign idle_wr   = cmd.wr && (state_reg == ST_IDLE);
    assign is_joint  = (mem_class_reg >= JOINT_FIRST) && (mem_class_reg <= JOINT_LAST);
    assign win_idx   = cmd.addr[4:0];
    assign ctrl_go   = idle_wr && (cmd.addr == ADDR_CONTROL_HI);
    assign ctrl_word = {cmd.data, ctrl_lo_reg};
    assign finish_go = ctrl_go && (ctrl_word == SUB_JOINT_POLL) && joint_mode_reg
                       && (joint_mask_reg == JOINT_ALL);

    // ==========================================================
    // checksum over the window
    always_comb begin
        win_sum = 8'h00;
        for (int i = 0; i < WINDOW_BYTES; i++) begin
            win_sum = 8'(win_sum + window_reg[i]);
        end
    end

    // ==========================================================
    // block select decode
    always_comb begin
        load_go    = 1'b0;
        load_class = class_reg;
        load_block = cmd.data[BLK_W-1:0];
        if (idle_wr && (cmd.addr == ADDR_BLOCK)) begin
            if (locked) begin
                if ((cmd.data >= MAKER_SEL_A) && (cmd.data <= MAKER_SEL_C)) begin
                    load_go    = 1'b1;
                    load_class = MAKER_CLASS;
                    load_block = BLK_W'(cmd.data - MAKER_SEL_A);
                end
            end else if ((setup_reg == SETUP_GENERAL) && ((cmd.data >> BLK_W) == 8'h00)) begin
                load_go = 1'b1;
            end
        end
    end

    // ==========================================================
    // checksum write decode
    always_comb begin
        target_ok = 1'b0;
        if (loaded_reg && !(is_joint && joint_lock_reg)) begin
            if (locked) begin
                target_ok = (mem_class_reg == MAKER_CLASS) && (mem_block_reg != '0)
                            && (32'(mem_block_reg) < MAKER_PAGES);
            end else begin
                target_ok = (setup_reg == SETUP_GENERAL) && (!is_joint || joint_mode_reg);
            end
        end
    end

    assign commit_go = idle_wr && (cmd.addr == ADDR_CHECKSUM) && target_ok
                       && (cmd.data == 8'(CHECKSUM_BASE - win_sum));

    // ==========================================================
    // command registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            class_reg    <= 8'h00;
            block_reg    <= 8'h00;
            setup_reg    <= SETUP_RESET;
            checksum_reg <= 8'h00;
            ctrl_lo_reg  <= 8'h00;
            control_reg  <= 16'h0000;
        end else if (ce && idle_wr) begin
            case (cmd.addr)
                ADDR_CONTROL_LO: ctrl_lo_reg <= cmd.data;
                ADDR_CONTROL_HI: control_reg <= ctrl_word;
                ADDR_CLASS: begin
                    if (!locked) begin
                        class_reg <= cmd.data;
                    end
                end
                ADDR_SETUP: begin
                    if (!locked) begin
                        setup_reg <= cmd.data;
                    end
                end
                ADDR_BLOCK: begin
                    if (load_go) begin
                        block_reg <= cmd.data;
                    end
                end
                ADDR_CHECKSUM: checksum_reg <= cmd.data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // load / commit / wait sequencer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 6'h00;
            wait_reg      <= '0;
            mem_class_reg <= 8'h00;
            mem_block_reg <= '0;
            loaded_reg    <= 1'b0;
            busy_reg      <= 1'b0;
        end else if (ce) begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 6'h00;
                    if (load_go) begin
                        state_reg     <= ST_LOAD;
                        mem_class_reg <= load_class;
                        mem_block_reg <= load_block;
                        loaded_reg    <= 1'b0;
                        busy_reg      <= 1'b1;
                    end else if (commit_go) begin
                        state_reg <= ST_COMMIT;
                        busy_reg  <= 1'b1;
                        wait_reg  <= joint_mode_reg ? WAIT_W'(JOINT_WAIT)
                                                    : WAIT_W'(COMMIT_WAIT);
                    end else if (finish_go) begin
                        state_reg <= ST_WAIT;
                        busy_reg  <= 1'b1;
                        wait_reg  <= WAIT_W'(JOINT_WAIT);
                    end
                end
                ST_LOAD: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'(WINDOW_BYTES)) begin
                        state_reg  <= ST_IDLE;
                        loaded_reg <= 1'b1;
                        busy_reg   <= 1'b0;
                    end
                end
                ST_COMMIT: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'(WINDOW_BYTES - 1)) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_reg <= WAIT_W'(1)) begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end else begin
                        wait_reg <= wait_reg - WAIT_W'(1);
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // window: host edits and block loads
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < WINDOW_BYTES; i++) begin
                window_reg[i] <= 8'h00;
            end
        end else if (ce) begin
            if ((state_reg == ST_LOAD) && (cnt_reg != 6'h00)) begin
                window_reg[5'(cnt_reg - 6'h01)] <= mem_rdata;
            end else if (idle_wr && (cmd.addr >= ADDR_WINDOW)
                         && (cmd.addr <= ADDR_WINDOW_LAST)) begin
                window_reg[win_idx] <= cmd.data;
            end
        end
    end

    nvm_bytes #(
        .ADDR_W (MEM_AW),
        .DATA_W (8)
    ) u_store (
        .clk_sys   (clk_sys),
        .ce        (ce),
        .we        (state_reg == ST_COMMIT),
        .addr      ({mem_class_reg, mem_block_reg, cnt_reg[4:0]}),
        .wdata     (window_reg[cnt_reg[4:0]]),
        .rdata_reg (mem_rdata)
    );

    // ==========================================================
    // joint write of the four classes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            joint_mode_reg <= 1'b0;
            joint_mask_reg <= 4'h0;
            joint_lock_reg <= 1'b0;
            prep_reg       <= '0;
        end else if (ce) begin
            if (prep_reg != '0) begin
                prep_reg <= prep_reg - WAIT_W'(1);
            end
            if (ctrl_go && (ctrl_word == SUB_JOINT_START) && !joint_lock_reg) begin
                joint_mode_reg <= 1'b1;
                joint_mask_reg <= 4'h0;
                prep_reg       <= WAIT_W'(PREP_WAIT);
            end else if (finish_go) begin
                joint_mode_reg <= 1'b0;
                joint_lock_reg <= 1'b1;
            end else if (commit_go && is_joint) begin
                joint_mask_reg[mem_class_reg[1:0]] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // stored limits shadow
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            limits_reg <= '{DEF_OTC_TH, DEF_OTC_REC, DEF_OTC_TIME, DEF_OTD_TH, DEF_OTD_REC,
                            DEF_OTD_TIME, DEF_TAPER_I, DEF_TAPER_V, DEF_TAPER_WIN};
        end else if (ce && commit_go && (mem_block_reg == '0)) begin
            if (mem_class_reg == SAFETY_CLASS) begin
                limits_reg.otc_th   <= {window_reg[OFS_OTC_TH], window_reg[OFS_OTC_TH+1]};
                limits_reg.otc_time <= window_reg[OFS_OTC_TIME];
                limits_reg.otc_rec  <= {window_reg[OFS_OTC_REC], window_reg[OFS_OTC_REC+1]};
                limits_reg.otd_th   <= {window_reg[OFS_OTD_TH], window_reg[OFS_OTD_TH+1]};
                limits_reg.otd_time <= window_reg[OFS_OTD_TIME];
                limits_reg.otd_rec  <= {window_reg[OFS_OTD_REC], window_reg[OFS_OTD_REC+1]};
            end else if (mem_class_reg == TAPER_CLASS) begin
                limits_reg.taper_i   <= {window_reg[OFS_TAPER_I], window_reg[OFS_TAPER_I+1]};
                limits_reg.taper_v   <= {window_reg[OFS_TAPER_V], window_reg[OFS_TAPER_V+1]};
                limits_reg.taper_win <= window_reg[OFS_TAPER_W];
            end
        end
    end

    // ==========================================================
    // read port
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else if (ce) begin
            rd_valid_reg <= cmd.rd;
            if (cmd.rd) begin
                if ((cmd.addr >= ADDR_WINDOW) && (cmd.addr <= ADDR_WINDOW_LAST)) begin
                    rd_data_reg <= window_reg[win_idx];
                end else begin
                    case (cmd.addr)
                        ADDR_CONTROL_LO: begin
                            rd_data_reg <= 8'h00;
                            rd_data_reg[STAT_JOINT_BIT] <= joint_mode_reg;
                            rd_data_reg[STAT_PREP_BIT]  <= (prep_reg != '0);
                            rd_data_reg[STAT_LOCK_BIT]  <= joint_lock_reg;
                        end
                        ADDR_CLASS:    rd_data_reg <= locked ? 8'h00 : class_reg;
                        ADDR_BLOCK:    rd_data_reg <= block_reg;
                        ADDR_CHECKSUM: rd_data_reg <= checksum_reg;
                        ADDR_SETUP:    rd_data_reg <= locked ? 8'h00 : setup_reg;
                        default:       rd_data_reg <= 8'h00;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // protection and termination flags
    logic [2:0] q_set;
    logic [2:0] q_clr;
    logic [7:0] q_time [3];
    logic [2:0] q_flag;

    assign q_set[0]  = gauge.charging && (gauge.temp >= limits_reg.otc_th);
    assign q_clr[0]  = gauge.temp <= limits_reg.otc_rec;
    assign q_time[0] = limits_reg.otc_time;
    assign q_set[1]  = gauge.discharging && (gauge.temp >= limits_reg.otd_th);
    assign q_clr[1]  = gauge.temp <= limits_reg.otd_rec;
    assign q_time[1] = limits_reg.otd_time;
    assign q_set[2]  = gauge.charging && (gauge.current <= limits_reg.taper_i)
                       && (gauge.voltage >= 16'(CHARGE_V - limits_reg.taper_v));
    assign q_clr[2]  = !gauge.charging;
    assign q_time[2] = limits_reg.taper_win;

    generate
        for (genvar g = 0; g < 3; g++) begin : g_flag
            flag_qualify u_q (
                .clk_sys   (clk_sys),
                .nrst      (nrst),
                .ce        (ce),
                .set_cond  (q_set[g]),
                .clr_cond  (q_clr[g]),
                .tick      (gauge.tick_1s),
                .qual_time (q_time[g]),
                .flag_reg  (q_flag[g])
            );
        end
    endgenerate

    assign charge_overtemp_flag    = q_flag[0];
    assign discharge_overtemp_flag = q_flag[1];
    assign charge_done_flag        = q_flag[2];

endmodule // config_store_block_access

// ==== verilog/flag_qualify.sv ====
`timescale 1ns/1ps
module flag_qualify (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       set_cond,
    input  wire logic       clr_cond,
    input  wire logic       tick,
    input  wire logic [7:0] qual_time,
    output logic            flag_reg
);

    logic [7:0] sec_reg;

    // ==========================================================
    // qualified set, recovery clear, zero time disables
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
            sec_reg  <= 8'h00;
        end else if (ce) begin
            if (qual_time == 8'h00) begin
                flag_reg <= 1'b0;
                sec_reg  <= 8'h00;
            end else if (flag_reg) begin
                sec_reg <= 8'h00;
                if (clr_cond) begin
                    flag_reg <= 1'b0;
                end
            end else if (!set_cond) begin
                sec_reg <= 8'h00;
            end else if (tick) begin
                if (sec_reg + 8'h01 >= qual_time) begin
                    flag_reg <= 1'b1;
                    sec_reg  <= 8'h00;
                end else begin
                    sec_reg <= sec_reg + 8'h01;
                end
            end
        end
    end

endmodule // flag_qualify

// ==== verilog/nvm_bytes.sv ====
`timescale 1ns/1ps
module nvm_bytes #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              ce,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata_reg
);

    // ==========================================================
    // byte store, registered read
    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata_reg <= mem[addr];
        end
    end

endmodule // nvm_bytes
